// >>> design/pvc_pkg.sv
/*
  Constants and types for the vendor configuration register bank of a
  10/100 transceiver: register numbers, field positions, reset values,
  write masks and timing of the internal state-machine reset.
  Assumes one 20 MHz system clock that also samples the management pins.
*/
package pvc_pkg;

  // Register numbers on the management bus
  localparam logic [4:0] PVC_REG_CTL_LOW   = 5'h10;
  localparam logic [4:0] PVC_REG_MODE_ADDR = 5'h11;
  localparam logic [4:0] PVC_REG_TEN_CFG   = 5'h12;
  localparam logic [4:0] PVC_REG_PD_TEST   = 5'h13;
  localparam logic [4:0] PVC_REG_SPEC_CFG  = 5'h14;

  // Field positions, control low register
  localparam int PVC_B_FSM_RST   = 3;
  localparam int PVC_B_PRE_SKIP  = 2;
  localparam int PVC_B_SLEEP     = 1;
  localparam int PVC_B_LOOPOUT   = 0;

  // Field positions, mode and address register
  localparam int PVC_B_MODE_LSB  = 12;
  localparam int PVC_B_ADDR_LSB  = 4;

  // Field positions, 10BASE-T register
  localparam int PVC_B_LINK_PULSE_ENABLE     = 14;
  localparam int PVC_B_HBE       = 13;
  localparam int PVC_B_SQUELCH   = 12;
  localparam int PVC_B_JABBER    = 11;
  localparam int PVC_B_SERIAL    = 10;

  // Field positions, special config register
  localparam int PVC_B_SD_FORCE  = 13;
  localparam int PVC_B_SHORT_PRE = 11;
  localparam int PVC_B_TX_SAVE   = 10;
  localparam int PVC_B_ANEG_PSO  = 9;
  localparam int PVC_B_XOVER     = 7;
  localparam int PVC_B_ANEG_LOOP = 6;
  localparam int PVC_B_XOVER_VAL = 5;
  localparam int PVC_B_XOVER_MAN = 4;
  localparam int PVC_B_PD_LEVEL  = 0;

  // Reset values and writable masks
  localparam logic [3:0]  PVC_MODE_RST     = 4'hF;
  localparam logic [15:0] PVC_SPEC_WMASK   = 16'hFE7F;
  localparam logic [15:0] PVC_SPEC_RST     = 16'h0000;
  localparam logic [8:0]  PVC_PD_SEL_RST   = 9'h000;

  // Preamble cut encodings
  localparam logic [1:0]  PVC_CUT_NONE     = 2'h0;
  localparam logic [1:0]  PVC_CUT_10       = 2'h1;
  localparam logic [1:0]  PVC_CUT_20       = 2'h2;

  // Management frame figures
  localparam logic [5:0]  PVC_PRE_ONES     = 6'h20;
  localparam logic [4:0]  PVC_HDR_LAST     = 5'h0C;
  localparam logic [4:0]  PVC_DATA_LAST    = 5'h0F;
  localparam logic [1:0]  PVC_OP_WRITE     = 2'h1;
  localparam logic [1:0]  PVC_OP_READ      = 2'h2;

  // State-machine reset pulse length
  localparam int PVC_CLK_MHZ      = 20;
  localparam int PVC_FSM_RST_NS   = 200;
  localparam int PVC_FSM_RST_CYC  = (PVC_FSM_RST_NS * PVC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PVC_FSM_RST_LOAD = 4'(PVC_FSM_RST_CYC);

  // Frame receiver states
  typedef enum logic [2:0] {
    PVC_S_PRE  = 3'b000,
    PVC_S_HDR  = 3'b001,
    PVC_S_TA   = 3'b010,
    PVC_S_DATA = 3'b011
  } pvc_st_t;

endpackage

// >>> design/pvc_regs.sv
/*
  Vendor configuration and status registers (16 low bits, 17 to 20) of a
  10/100 transceiver, with their clause 22 management frame slave.
  Assumes MDC and MDIO arrive synchronous to i_clk and far slower than it;
  the surrounding PHY supplies link status and takes the control levels.
*/
// Notes on behaviour
// RQ1 - Writing one to fsm reset bit pulses state machine reset; bit clears itself.
// RQ2 - Management preamble skip bit, resets to one; one allows frames without preamble.
// RQ3 - Sleep bit one powers down all but oscillator and clock generator.
// RQ4 - Clearing sleep keeps configuration and resets the state machines.
// RQ5 - Remote loopout bit one loops received data onto transmit channel.
// RQ6 - Negotiation completion sets exactly one of four read-only mode bits.
// RQ7 - Five-bit PHY address, strapped at reset, writable, sent MSB first.
// RQ8 - Four-bit read-only negotiation monitor code reports negotiation progress.
// RQ9 - At 10 Mb/s link pulse enable sends pulses; zero forces link good.
// RQ10 - Heartbeat enable, reset one, is ignored in full duplex.
// RQ11 - Jabber enable acts in 10BASE-T full duplex or transceiver loopback.
// RQ12 - Serial select strapped; chooses seven-wire interface, never at 100 Mb/s.
// RQ13 - Read-only polarity flag follows detected reversed 10 Mb/s polarity.
// RQ14 - Selected power-down test bits take the common power-down level.
// RQ15 - Force signal detect bit makes 100 Mb/s signal detect good.
// RQ16 - Preamble saving zero with saving set cuts preamble 10 or 20 bits.
// RQ17 - Transmit power saving bit enables 10 Mb/s saving; resets to zero.
// RQ18 - Negotiation power saving bit is inverted: zero enables saving.
// RQ19 - Read-only crossover bit shows crossed one or straight zero.
// RQ20 - Manual crossover zero runs automatic; one follows the force value.
// RQ21 - Negotiation loopback bit runs digital negotiation loopback test.
// RQ22 - Reserved bits read zero; writes to them are ignored.
// RQ23 - Registers reached by clause 22 frames addressed by PHY and register.
`timescale 1ns/1ps
module pvc_regs
  import pvc_pkg::*;
#(
  parameter int NUM_PD_BLOCKS = 9
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Management pins
  input  wire logic                     i_mdc,
  input  wire logic                     i_mdio,
  output logic                          o_mdio,
  output logic                          o_mdio_oe,
  // Straps
  input  wire logic [4:0]               i_strap_phy_addr,
  input  wire logic                     i_strap_serial,
  // Status from the PHY core
  input  wire logic                     i_aneg_done,
  input  wire logic                     i_aneg_speed100,
  input  wire logic                     i_aneg_full,
  input  wire logic [3:0]               i_aneg_monitor,
  input  wire logic                     i_speed100,
  input  wire logic                     i_full_duplex,
  input  wire logic                     i_xcvr_loopback,
  input  wire logic                     i_polarity_rev,
  input  wire logic                     i_signal_detect,
  input  wire logic                     i_auto_crossover,
  input  wire logic                     i_preamble_cut10,
  // Controls to the PHY core
  output logic                          o_fsm_reset,
  output logic                          o_sleep,
  output logic                          o_remote_loopout,
  output logic                          o_link_pulse_tx,
  output logic                          o_link_force_good,
  output logic                          o_heartbeat_en,
  output logic                          o_jabber_en,
  output logic                          o_squelch_normal,
  output logic                          o_serial_mode,
  output logic [NUM_PD_BLOCKS-1:0]      o_block_pd,
  output logic                          o_sig_detect_ok,
  output logic [1:0]                    o_preamble_cut,
  output logic                          o_tx_low_speed_save,
  output logic                          o_aneg_power_save,
  output logic                          o_crossover,
  output logic                          o_aneg_digital_loop,
  output logic [15:0]                   o_spec_cfg
);
  import pvc_pkg::*;

  // Assertion clock and reset for the whole module
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Power-down test register is fixed at nine blocks
  if (NUM_PD_BLOCKS != 9) begin : g_pd_count_bad
    $error("pvc_regs: power-down test register holds exactly 9 blocks");
  end

  typedef struct packed {
    logic                     mdc;
    pvc_st_t                  st;
    logic [4:0]               cnt;
    logic [5:0]               ones;
    logic [15:0]              sh;
    logic                     rd;
    logic [4:0]               regad;
    logic                     mdo;
    logic                     mdoe;
    logic                     strapped;
    logic [3:0]               rst_cnt;
    logic                     pre_skip;
    logic                     sleep;
    logic                     loopout;
    logic [3:0]               mode;
    logic [4:0]               phy_addr;
    logic                     link_pulse_enable;
    logic                     heartbeat_enable;
    logic                     squelch;
    logic                     jabber;
    logic                     serial;
    logic [8:0]               pd_sel;
    logic [15:0]              spec;
  } pvc_state_t;

  pvc_state_t s_q;
  pvc_state_t s_d;

  logic        mdc_rise;
  logic [12:0] hdr;
  logic [15:0] rdata;
  logic [15:0] wdata;
  logic        wr_fire;
  logic        xover;

  // Edge of the management clock and assembled header
  assign mdc_rise = i_mdc & ~s_q.mdc;
  assign hdr      = {s_q.sh[11:0], i_mdio};
  assign wdata    = {s_q.sh[14:0], i_mdio};
  assign wr_fire  = mdc_rise && (s_q.st == PVC_S_DATA) && !s_q.rd && (s_q.cnt == PVC_DATA_LAST);

  // Crossover state, manual or automatic
  assign xover = s_q.spec[PVC_B_XOVER_MAN] ? s_q.spec[PVC_B_XOVER_VAL] : i_auto_crossover; // RQ20

  // Read data assembly; unlisted bits stay zero
  always_comb begin
    rdata = 16'h0000;                                            // RQ22
    case (s_q.regad)
      PVC_REG_CTL_LOW: begin
        rdata[PVC_B_FSM_RST]  = o_fsm_reset;
        rdata[PVC_B_PRE_SKIP] = s_q.pre_skip;
        rdata[PVC_B_SLEEP]    = s_q.sleep;
        rdata[PVC_B_LOOPOUT]  = s_q.loopout;
      end
      PVC_REG_MODE_ADDR: begin
        rdata[PVC_B_MODE_LSB +: 4] = s_q.mode;                   // RQ6
        rdata[PVC_B_ADDR_LSB +: 5] = s_q.phy_addr;               // RQ7
        rdata[3:0]                 = i_aneg_monitor;             // RQ8
      end
      PVC_REG_TEN_CFG: begin
        rdata[PVC_B_LINK_PULSE_ENABLE]   = s_q.link_pulse_enable;
        rdata[PVC_B_HBE]     = s_q.heartbeat_enable;
        rdata[PVC_B_SQUELCH] = s_q.squelch;
        rdata[PVC_B_JABBER]  = s_q.jabber;
        rdata[PVC_B_SERIAL]  = s_q.serial;
        rdata[0]             = i_polarity_rev;                   // RQ13
      end
      PVC_REG_PD_TEST: begin
        rdata[8:0] = s_q.pd_sel;
      end
      PVC_REG_SPEC_CFG: begin
        rdata             = s_q.spec & PVC_SPEC_WMASK;
        rdata[PVC_B_XOVER] = xover;                              // RQ19
      end
      default: begin
        rdata = 16'h0000;
      end
    endcase
  end

  // Next state: frame slave, register writes, self-clearing reset
  always_comb begin
    s_d     = s_q;
    s_d.mdc = i_mdc;
    // Straps caught once after reset release
    if (!s_q.strapped) begin
      s_d.strapped = 1'b1;
      s_d.phy_addr = i_strap_phy_addr;                           // RQ7
      s_d.serial   = i_strap_serial;                             // RQ12
    end
    // Reset pulse countdown; bit reads as zero once it ends
    if (s_q.rst_cnt != 4'h0) begin
      s_d.rst_cnt = s_q.rst_cnt - 4'h1;                          // RQ1
    end
    // Negotiation result as a one-hot mode
    if (i_aneg_done) begin
      case ({i_aneg_speed100, i_aneg_full})                      // RQ6
        2'b11:   s_d.mode = 4'h8;
        2'b10:   s_d.mode = 4'h4;
        2'b01:   s_d.mode = 4'h2;
        default: s_d.mode = 4'h1;
      endcase
    end
    // Frame receiver, acting on management clock rising edges
    if (mdc_rise) begin
      case (s_q.st)
        PVC_S_PRE: begin
          if (i_mdio) begin
            if (s_q.ones != PVC_PRE_ONES) begin
              s_d.ones = s_q.ones + 6'h01;
            end
          end else if ((s_q.ones == PVC_PRE_ONES) || s_q.pre_skip) begin // RQ2
            s_d.st  = PVC_S_HDR;
            s_d.cnt = 5'h00;
            s_d.sh  = 16'h0000;
          end else begin
            s_d.ones = 6'h00;
          end
        end
        PVC_S_HDR: begin
          s_d.sh  = {s_q.sh[14:0], i_mdio};
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == PVC_HDR_LAST) begin
            s_d.cnt   = 5'h00;
            s_d.ones  = 6'h00;
            s_d.regad = hdr[4:0];
            s_d.rd    = (hdr[11:10] == PVC_OP_READ);
            if (hdr[12] && (hdr[9:5] == s_q.phy_addr) &&
                ((hdr[11:10] == PVC_OP_READ) || (hdr[11:10] == PVC_OP_WRITE))) begin // RQ23
              s_d.st = PVC_S_TA;
            end else begin
              s_d.st = PVC_S_PRE;
            end
          end
        end
        PVC_S_TA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00) begin
            // Drive the turnaround zero for reads
            s_d.mdoe = s_q.rd;
            s_d.mdo  = 1'b0;
            s_d.sh   = rdata;
          end else begin
            s_d.st  = PVC_S_DATA;
            s_d.cnt = 5'h00;
            if (s_q.rd) begin
              s_d.mdo = s_q.sh[15];                              // RQ7
              s_d.sh  = {s_q.sh[14:0], 1'b0};
            end
          end
        end
        PVC_S_DATA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.rd) begin
            s_d.mdo = s_q.sh[15];
            s_d.sh  = {s_q.sh[14:0], 1'b0};
          end else begin
            s_d.sh = wdata;
          end
          if (s_q.cnt == PVC_DATA_LAST) begin
            s_d.st   = PVC_S_PRE;
            s_d.mdoe = 1'b0;
            s_d.mdo  = 1'b0;
          end
        end
        default: begin
          s_d.st   = PVC_S_PRE;
          s_d.mdoe = 1'b0;
        end
      endcase
    end
    // Register writes, reserved bits dropped
    if (wr_fire) begin
      case (s_q.regad)
        PVC_REG_CTL_LOW: begin
          s_d.pre_skip = wdata[PVC_B_PRE_SKIP];                  // RQ2
          s_d.sleep    = wdata[PVC_B_SLEEP];                     // RQ3
          s_d.loopout  = wdata[PVC_B_LOOPOUT];                   // RQ5
          if (wdata[PVC_B_FSM_RST] || (s_q.sleep && !wdata[PVC_B_SLEEP])) begin
            s_d.rst_cnt = PVC_FSM_RST_LOAD;                      // RQ1 RQ4
          end
        end
        PVC_REG_MODE_ADDR: begin
          s_d.phy_addr = wdata[PVC_B_ADDR_LSB +: 5];             // RQ7
        end
        PVC_REG_TEN_CFG: begin
          s_d.link_pulse_enable   = wdata[PVC_B_LINK_PULSE_ENABLE];
          s_d.heartbeat_enable     = wdata[PVC_B_HBE];
          s_d.squelch = wdata[PVC_B_SQUELCH];
          s_d.jabber  = wdata[PVC_B_JABBER];
          s_d.serial  = wdata[PVC_B_SERIAL];
        end
        PVC_REG_PD_TEST: begin
          s_d.pd_sel = wdata[8:0];
        end
        PVC_REG_SPEC_CFG: begin
          s_d.spec = wdata & PVC_SPEC_WMASK;                     // RQ22
        end
        default: begin
          s_d.spec = s_q.spec;
        end
      endcase
    end
  end

  // State register; sleep leaves configuration untouched
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q          <= '0;
      s_q.st       <= PVC_S_PRE;
      s_q.pre_skip <= 1'b1;                                      // RQ2
      s_q.mode     <= PVC_MODE_RST;
      s_q.link_pulse_enable    <= 1'b1;
      s_q.heartbeat_enable      <= 1'b1;
      s_q.squelch  <= 1'b1;
      s_q.jabber   <= 1'b1;
      s_q.pd_sel   <= PVC_PD_SEL_RST;
      s_q.spec     <= PVC_SPEC_RST;                              // RQ17 RQ18
    end else begin
      s_q <= s_d;
    end
  end

  // Per-block power-down test levels
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PD_BLOCKS; gi++) begin : g_pd
      assign o_block_pd[gi] = s_q.pd_sel[gi] & s_q.spec[PVC_B_PD_LEVEL]; // RQ14
    end
  endgenerate

  // Management pin drive
  assign o_mdio    = s_q.mdo;
  assign o_mdio_oe = s_q.mdoe;

  // Controls to the PHY core
  assign o_fsm_reset         = (s_q.rst_cnt != 4'h0);            // RQ1
  assign o_sleep             = s_q.sleep;                        // RQ3
  assign o_remote_loopout    = s_q.loopout;                      // RQ5
  assign o_link_pulse_tx     = s_q.link_pulse_enable & ~i_speed100;          // RQ9
  assign o_link_force_good   = ~s_q.link_pulse_enable & ~i_speed100;         // RQ9
  assign o_heartbeat_en      = s_q.heartbeat_enable & ~i_full_duplex;         // RQ10
  assign o_jabber_en         = (~i_speed100 & (i_full_duplex | i_xcvr_loopback)) ? s_q.jabber : 1'b1; // RQ11
  assign o_squelch_normal    = s_q.squelch;
  assign o_serial_mode       = s_q.serial & ~i_speed100;         // RQ12
  assign o_sig_detect_ok     = s_q.spec[PVC_B_SD_FORCE] | i_signal_detect; // RQ15
  assign o_preamble_cut      = (!s_q.spec[PVC_B_SHORT_PRE] && s_q.spec[PVC_B_TX_SAVE]) ?
                               (i_preamble_cut10 ? PVC_CUT_10 : PVC_CUT_20) : PVC_CUT_NONE; // RQ16
  assign o_tx_low_speed_save = s_q.spec[PVC_B_TX_SAVE];          // RQ17
  assign o_aneg_power_save   = ~s_q.spec[PVC_B_ANEG_PSO];        // RQ18
  assign o_crossover         = xover;                            // RQ19
  assign o_aneg_digital_loop = s_q.spec[PVC_B_ANEG_LOOP];        // RQ21
  assign o_spec_cfg          = s_q.spec;

  // Checks on the block's own behaviour

  sequence fsm_rst_write;
    wr_fire && (s_q.regad == PVC_REG_CTL_LOW) && wdata[PVC_B_FSM_RST];
  endsequence

  sequence fsm_rst_pulse;
    o_fsm_reset [*4] ##1 !o_fsm_reset;
  endsequence

  a_fsm_self_clear: assert property (fsm_rst_write |=> fsm_rst_pulse) // RQ1
    else $error("state machine reset did not last four cycles and clear");
  a_wake_resets_fsm: assert property ($fell(o_sleep) |-> o_fsm_reset) // RQ4
    else $error("leaving sleep did not reset the state machines");
  a_mode_one_hot: assert property (i_aneg_done |=> $onehot(s_q.mode)) // RQ6
    else $error("negotiation result not one-hot");
  a_link_pulse_off: assert property (!i_speed100 && !s_q.link_pulse_enable |-> o_link_force_good && !o_link_pulse_tx) // RQ9
    else $error("link pulses not stopped with link forced good");
  a_heartbeat_fdx: assert property (i_full_duplex |-> !o_heartbeat_en) // RQ10
    else $error("heartbeat enabled in full duplex");
  a_serial_not_fast: assert property (i_speed100 |-> !o_serial_mode) // RQ12
    else $error("serial mode active at 100 Mb/s");
  a_pd_level_low: assert property (!s_q.spec[PVC_B_PD_LEVEL] |-> (o_block_pd == '0)) // RQ14
    else $error("block powered down while level is normal");
  a_preamble_cut: assert property (s_q.spec[PVC_B_SHORT_PRE] |-> (o_preamble_cut == PVC_CUT_NONE)) // RQ16
    else $error("preamble cut while saving control is off");
  a_xover_manual: assert property (s_q.spec[PVC_B_XOVER_MAN] |-> (o_crossover == s_q.spec[PVC_B_XOVER_VAL])) // RQ20
    else $error("manual crossover not following force value");
  a_ta_read_drive: assert property (mdc_rise && (s_q.st == PVC_S_TA) && (s_q.cnt == 5'h00) && s_q.rd
                                    |=> o_mdio_oe && !o_mdio) // RQ23
    else $error("read turnaround not driven low");

endmodule // pvc_regs

// >>> test/phy_vendor_config_regs_tb_top.sv
/*
  Self-checking bench for the vendor configuration register bank.
  Assumes pvc_regs and the station manager model; MDIO has a pull-up.
*/
`timescale 1ns/1ps
module phy_vendor_config_regs_tb_top;
  import pvc_pkg::*;

  localparam logic [4:0] STRAP_ADDR = 5'h13;

  // Design pins
  logic        i_clk, i_rst, i_mdc, i_mdio, o_mdio, o_mdio_oe, i_aneg_done, i_aneg_speed100, i_aneg_full;
  logic        i_speed100, i_full_duplex, i_xcvr_loopback, i_polarity_rev, i_signal_detect;
  logic        i_auto_crossover, i_preamble_cut10, o_fsm_reset, o_sleep, o_remote_loopout;
  logic        o_link_pulse_tx, o_link_force_good, o_heartbeat_en, o_jabber_en, o_squelch_normal;
  logic        o_serial_mode, o_sig_detect_ok, o_tx_low_speed_save, o_aneg_power_save;
  logic        o_crossover, o_aneg_digital_loop, sta_mdio, sta_oe, rd_strobe, strap_ser;
  logic [3:0]  i_aneg_monitor, mode;
  logic [8:0]  o_block_pd;
  logic [1:0]  o_preamble_cut;
  logic [4:0]  phy;
  logic [15:0] o_spec_cfg, rd_data, w, s;
  logic [15:0] exp_q[$];
  int          mismatches, cmp_count, seed, plen, hi;

  // Wire with pull-up
  assign i_mdio = o_mdio_oe ? o_mdio : (sta_oe ? sta_mdio : 1'b1);

  pvc_regs DUT (
    .i_clk, .i_rst, .i_mdc, .i_mdio, .o_mdio, .o_mdio_oe,
    .i_strap_phy_addr(STRAP_ADDR), .i_strap_serial(strap_ser),
    .i_aneg_done, .i_aneg_speed100, .i_aneg_full, .i_aneg_monitor, .i_speed100, .i_full_duplex,
    .i_xcvr_loopback, .i_polarity_rev, .i_signal_detect, .i_auto_crossover, .i_preamble_cut10,
    .o_fsm_reset, .o_sleep, .o_remote_loopout, .o_link_pulse_tx, .o_link_force_good, .o_heartbeat_en,
    .o_jabber_en, .o_squelch_normal, .o_serial_mode, .o_block_pd, .o_sig_detect_ok, .o_preamble_cut,
    .o_tx_low_speed_save, .o_aneg_power_save, .o_crossover, .o_aneg_digital_loop, .o_spec_cfg
  );

  pvc_sta_model sta (
    .i_clk, .i_mdio_wire(i_mdio), .o_mdc(i_mdc), .o_mdio(sta_mdio), .o_mdio_oe(sta_oe),
    .o_rd_strobe(rd_strobe), .o_rd_data(rd_data)
  );

  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Register access through full-preamble frames
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    sta.frame(32, PVC_OP_READ, phy, a, 16'h0000);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    sta.frame(32, PVC_OP_WRITE, phy, a, d);
    repeat (8) @(negedge i_clk);
  endtask

  // Length of the last state-machine reset pulse
  always @(posedge i_clk) begin
    if (o_fsm_reset === 1'b1) hi <= hi + 1;
    else if (hi != 0) begin
      plen <= hi;
      hi   <= 0;
    end
  end

  // Read results against the oldest note
  initial forever begin
    @(posedge rd_strobe);
    check(rd_data, exp_q.pop_front());
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end

  // Main sequence
  initial begin
    i_rst = 1'b1; seed = 8; phy = STRAP_ADDR; mode = 4'hF; hi = 0; plen = 0; i_aneg_monitor = 4'h0;
    strap_ser = 1'b1;
    {i_aneg_done, i_aneg_speed100, i_aneg_full, i_speed100, i_full_duplex, i_xcvr_loopback} = 6'h00;
    {i_polarity_rev, i_signal_detect, i_auto_crossover, i_preamble_cut10} = 4'hA;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    rd(PVC_REG_CTL_LOW, 16'h0004);
    rd(PVC_REG_MODE_ADDR, {4'hF, 3'h0, phy, 4'h0});
    rd(PVC_REG_TEN_CFG, 16'h7C01);
    rd(PVC_REG_PD_TEST, 16'h0000);
    rd(PVC_REG_SPEC_CFG, 16'h0080);
    rd(5'h15, 16'h0000);
    exp_q.push_back(16'hFFFF);
    sta.frame(32, PVC_OP_READ, phy ^ 5'h01, PVC_REG_CTL_LOW, 16'h0000);
    // Illegal opcode must not act as a write
    sta.frame(32, 2'h3, phy, PVC_REG_CTL_LOW, 16'h0003);
    rd(PVC_REG_CTL_LOW, 16'h0004);
    $display("done: reset values and refusals");
    // New address, read-only fields untouched, monitor codes 0 to 8
    wr(PVC_REG_MODE_ADDR, 16'hFE5A);
    phy = 5'h05;
    for (int i = 0; i < 9; i++) begin
      i_aneg_monitor = 4'(i);
      if (i < 4) begin
        {i_aneg_speed100, i_aneg_full} = 2'(3 - i);
        i_aneg_done = 1'b1;
        @(negedge i_clk);
        i_aneg_done = 1'b0;
        mode = 4'h8 >> i;
      end
      rd(PVC_REG_MODE_ADDR, {mode, 3'h0, phy, 4'(i)});
    end
    $display("done: address and status");
    // Preamble skip off, then reset pulse, sleep and loop-out
    wr(PVC_REG_CTL_LOW, 16'h0000);
    exp_q.push_back(16'hFFFF);
    sta.frame(0, PVC_OP_READ, phy, PVC_REG_CTL_LOW, 16'h0000);
    rd(PVC_REG_CTL_LOW, 16'h0000);
    wr(PVC_REG_CTL_LOW, 16'h000C);
    exp_q.push_back(16'h0004);
    sta.frame(0, PVC_OP_READ, phy, PVC_REG_CTL_LOW, 16'h0000);
    check(16'(plen), 16'(PVC_FSM_RST_CYC));
    wr(PVC_REG_CTL_LOW, 16'h0006);
    check(16'(o_sleep), 16'h0001);
    plen = 0;
    wr(PVC_REG_CTL_LOW, 16'h0005);
    check(16'({o_sleep, o_remote_loopout}), 16'h0001);
    check(16'(plen), 16'(PVC_FSM_RST_CYC));
    rd(PVC_REG_CTL_LOW, 16'h0005);
    $display("done: control low register");
    // Random settings against the control outputs
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed));
      {i_speed100, i_full_duplex, i_xcvr_loopback, i_polarity_rev, i_signal_detect, i_auto_crossover,
       i_preamble_cut10} = 7'($random(seed));
      wr(PVC_REG_SPEC_CFG, w);
      wr(PVC_REG_TEN_CFG, w);
      wr(PVC_REG_PD_TEST, w);
      s = w & PVC_SPEC_WMASK;
      check(o_spec_cfg, s);
      check(16'(o_block_pd), 16'(w[8:0] & {9{w[0]}}));
      check(16'(o_sig_detect_ok), 16'(w[13] | i_signal_detect));
      check(16'(o_preamble_cut), 16'((!w[11] && w[10]) ?
            (i_preamble_cut10 ? PVC_CUT_10 : PVC_CUT_20) : PVC_CUT_NONE));
      check(16'({o_tx_low_speed_save, o_aneg_power_save}), 16'({w[10], !w[9]}));
      check(16'(o_crossover), 16'(w[4] ? w[5] : i_auto_crossover));
      check(16'(o_aneg_digital_loop), 16'(w[6]));
      check(16'({o_link_pulse_tx, o_link_force_good}), 16'({w[14], !w[14]} & {2{!i_speed100}}));
      check(16'(o_heartbeat_en), 16'(w[13] & !i_full_duplex));
      check(16'(o_jabber_en), 16'((!i_speed100 && (i_full_duplex || i_xcvr_loopback)) ? w[11] : 1'b1));
      check(16'({o_serial_mode, o_squelch_normal}), 16'({w[10] & !i_speed100, w[12]}));
      rd(PVC_REG_TEN_CFG, (w & 16'h7C00) | 16'(i_polarity_rev));
      rd(PVC_REG_PD_TEST, w & 16'h01FF);
      rd(PVC_REG_SPEC_CFG, s | (16'(w[4] ? w[5] : i_auto_crossover) << 7));
    end
    $display("done: random settings");
    // Second reset, serial strap now low
    strap_ser = 1'b0;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    phy = STRAP_ADDR;
    repeat (4) @(negedge i_clk);
    rd(PVC_REG_TEN_CFG, 16'h7800 | 16'(i_polarity_rev));
    rd(PVC_REG_MODE_ADDR, {4'hF, 3'h0, phy, i_aneg_monitor});
    $display("done: second reset");
    repeat (4) @(negedge i_clk);
    print_verdict();
  end
endmodule // phy_vendor_config_regs_tb_top

// >>> test/pvc_sta_model.sv
/*
  Station manager model: issues management frames on MDC and MDIO.
  Assumes the bench resolves the MDIO wire with a pull-up.
*/
`timescale 1ns/1ps
module pvc_sta_model
  import pvc_pkg::*;
(
  // Clock and resolved wire
  input  wire logic        i_clk,
  input  wire logic        i_mdio_wire,
  // Management pins
  output logic             o_mdc,
  output logic             o_mdio,
  output logic             o_mdio_oe,
  // Read results
  output logic             o_rd_strobe,
  output logic [15:0]      o_rd_data
);
  // Idle: clock parked low, line released
  initial begin
    o_mdc       = 1'b0;
    o_mdio      = 1'b1;
    o_mdio_oe   = 1'b0;
    o_rd_strobe = 1'b0;
    o_rd_data   = 16'h0000;
  end

  // One MDC period, wire sampled late in the high half
  task automatic mbit(input logic b, input logic drv, output logic s);
    @(negedge i_clk);
    o_mdc     = 1'b0;
    o_mdio    = b;
    o_mdio_oe = drv;
    repeat (2) @(negedge i_clk);
    o_mdc = 1'b1;
    repeat (2) @(negedge i_clk);
    s = i_mdio_wire;
  endtask

  // Whole frame; line released from turnaround on reads
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd);
    logic [31:0] f;
    logic [15:0] rd;
    logic        s;
    f  = {2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < pre; i++) mbit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      mbit(f[i], (op != PVC_OP_READ) || (i > 17), s);
      if (i >= 1 && i <= 16) rd[i-1] = s;
    end
    @(negedge i_clk);
    o_mdc     = 1'b0;
    o_mdio_oe = 1'b0;
    if (op == PVC_OP_READ) begin
      o_rd_data   = rd;
      o_rd_strobe = 1'b1;
      @(negedge i_clk);
      o_rd_strobe = 1'b0;
    end
  endtask
endmodule // pvc_sta_model
